// ---- include/pic_defines.svh ----
// Purpose: Offsets, reset values, field layouts and timing counts.
// Assumes: A 100 MHz system clock.
// Notes:   Cycle counts are derived from times in ms.
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PIC_OFS_CHG_STAT   8'h01
`define PIC_OFS_REG_STAT   8'h02
`define PIC_OFS_CHG_MASK   8'h03
`define PIC_OFS_REG_MASK   8'h04
`define PIC_OFS_CHG_ACK    8'h05
`define PIC_OFS_REG_ACK    8'h06
`define PIC_OFS_GPIO_MASK  8'h0f
`define PIC_OFS_GPIO_DEF   8'h10

// ----------------------------------------------------------------
// Reset values and field layouts
// ----------------------------------------------------------------
`define PIC_RST_ZERO       8'h00
`define PIC_RST_MASK       8'hff
`define PIC_RST_GPIO_MASK  8'h0f
`define PIC_RD_UNMAPPED    8'hff
`define PIC_CHG_EDGE       8'h21
`define PIC_CHG_LEVEL      8'hde
`define PIC_CHG_WCLR       8'h1e
`define PIC_REG_EDGE       8'he0
`define PIC_REG_LEVEL      8'h0f
`define PIC_I2C_ADDR6      6'h24

// ----------------------------------------------------------------
// Timing: times in ms, counts in clock cycles
// ----------------------------------------------------------------
`define PIC_CLK_KHZ        100000
`define PIC_DBC_MS         56
`define PIC_POR_FAST_MS    100
`define PIC_POR_SLOW_MS    1000
`define PIC_CPU_RST_MS     10
`define PIC_SD_UVLO_MS     1
`define PIC_SD_HOT_MS      1
`define PIC_SD_LID_MS      10
`define PIC_DBC_CYC        (`PIC_DBC_MS * `PIC_CLK_KHZ)
`define PIC_POR_FAST_CYC   (`PIC_POR_FAST_MS * `PIC_CLK_KHZ)
`define PIC_POR_SLOW_CYC   (`PIC_POR_SLOW_MS * `PIC_CLK_KHZ)
`define PIC_CPU_RST_CYC    (`PIC_CPU_RST_MS * `PIC_CLK_KHZ)
`define PIC_SD_UVLO_CYC    (`PIC_SD_UVLO_MS * `PIC_CLK_KHZ)
`define PIC_SD_HOT_CYC     (`PIC_SD_HOT_MS * `PIC_CLK_KHZ)
`define PIC_SD_LID_CYC     (`PIC_SD_LID_MS * `PIC_CLK_KHZ)

`endif

// ---- include/pic_pkg.sv ----
// Purpose: Shared types of the interrupt and reset controller.
// Assumes: Constants live in pic_defines.svh.
// Notes:   Gray codes in the order each machine's states are listed.
package pic_pkg;

  // Supervisor states: hold, delay, run, core wait, reset pulse.
  typedef enum logic [2:0] {
    POR_HOLD   = 3'h0,
    POR_DLY    = 3'h1,
    POR_RUN    = 3'h3,
    POR_CWAIT  = 3'h2,
    POR_CPULSE = 3'h6
  } pic_por_t;

  // Serial port states.
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_ADDR = 3'h1,
    I2C_AACK = 3'h3,
    I2C_WR   = 3'h2,
    I2C_RD   = 3'h6,
    I2C_RACK = 3'h7
  } pic_i2c_t;

endpackage

// ---- include/pic_dbc_if.sv ----
// Purpose: Carries one raw input and its debounced level.
// Assumes: Single clock domain.
// Notes:   filt is the debouncer end, user the consumer end.
`timescale 1ns/1ns
interface pic_dbc_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface // pic_dbc_if

// ---- hw/pic_debounce.sv ----
// Purpose: Debounces one button or switch input.
// Assumes: Raw input is synchronous to clk.
// Notes:   Level changes only after CYC stable cycles.
`timescale 1ns/1ns
module pic_debounce #(
  parameter int unsigned CYC  = 32'd16,
  parameter logic        INIT = 1'b0
) (
  input wire logic clk,  // System clock.
  input wire logic srst, // Synchronous reset.
  pic_dbc_if.filt  d     // Raw in, clean out.
);
  logic [31:0] cnt_q;
  logic        clean_q;
  logic        moved;
  logic        done;

  // ------------------------------------------------------------
  // Stability counter
  // ------------------------------------------------------------
  // A glitch restarts the count, so bounces never leak through.
  assign moved   = d.raw != clean_q;
  assign done    = moved && (cnt_q >= CYC - 32'd1);
  assign d.clean = clean_q;

  // R25: whole interval stable
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q   <= 32'h0;
      clean_q <= INIT;
    end
    else
    begin
      cnt_q   <= (moved && !done) ? cnt_q + 32'h1 : 32'h0;
      clean_q <= done ? d.raw : clean_q;
    end
  end
endmodule // pic_debounce

// ---- hw/pic_top.sv ----
// Purpose: Interrupt aggregation and reset supervision of the PMIC.
// Assumes: All inputs synchronous to clk; open-drain pins are
//          driven by outside buffers from the _n levels.
// Notes:   Registers are reached over the I2C slave port only.
// Summary of operation
// R1: Hold resets low until main rail good, delay.
// R2: Main rail below window reasserts system reset.
// R3: Power-fail on undervoltage, overtemperature, lid low.
// R4: Cut supplies after cause-specific delay.
// R5: Debounce lid, reset button, power button.
// R6: Lid removal warns the processor.
// R7: Reset button gives fixed processor reset pulse.
// R8: Power button leaves low power mode.
// R9: Button, lid, undervoltage flag and interrupt.
// R10: Any unmasked source pulls interrupt low.
// R11: GPIO edge polarity from upper mask bits.
// R12: Mask bits block sources; all masked at reset.
// R13: Events captured even while masked.
// R14: Status read sets acknowledge for set bits.
// R15: Status latched before shifting out.
// R16: Charge bits 5,0 edge set, ack clear.
// R17: Other charge bits follow source level.
// R18: Regulator bits 7-5 edge set, ack clear.
// R19: Power-good bits 3-0 follow source level.
// R20: Acknowledge clears when its status clears.
// R21: GPIO detect blocked by lower mask bits.
// R22: GPIO register shows direction and detect states.
// R23: Write charge bits 1-4 resets charger.
// R24: Interrupt active when set, unmasked, unacknowledged.
// R25: Debounce needs stable level whole interval.
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_top #(
  parameter int unsigned DBC_CYC  = `PIC_DBC_CYC,
  parameter int unsigned POR_FAST = `PIC_POR_FAST_CYC,
  parameter int unsigned POR_SLOW = `PIC_POR_SLOW_CYC,
  parameter int unsigned CPU_CYC  = `PIC_CPU_RST_CYC,
  parameter int unsigned SD_UVLO  = `PIC_SD_UVLO_CYC,
  parameter int unsigned SD_HOT   = `PIC_SD_HOT_CYC,
  parameter int unsigned SD_LID   = `PIC_SD_LID_CYC
) (
  input  wire logic       clk,          // 100 MHz clock.
  input  wire logic       srst,         // Sync reset, high.
  input  wire logic       scl_i,        // Serial clock level.
  input  wire logic       sda_i,        // Serial data level.
  output logic            sda_o,        // Serial data out, 0.
  output logic            sda_oe,       // Pull data line low.
  input  wire logic       addr_lsb,     // Slave address LSB.
  input  wire logic       tpor,         // Slow reset delay.
  input  wire logic       main_pgood,   // Main rail in window.
  input  wire logic       core_pgood,   // Core rail stable.
  input  wire logic       uvlo,         // Supply undervoltage.
  input  wire logic       overtemp,     // Junction too hot.
  input  wire logic       lid_in,       // Lid raw, high closed.
  input  wire logic       user_reset_button_n,  // Reset button raw.
  input  wire logic       pwr_button,   // Power button raw.
  input  wire logic       lp_mode,      // In low power mode.
  input  wire logic [7:0] chg_src,      // Charger sources.
  input  wire logic [3:0] reg_fail,     // Rails out of window.
  input  wire logic [3:0] gpio_in,      // GPIO pin levels.
  output logic            sys_rst_n,    // Global reset.
  output logic            cpu_rst_n,    // Processor reset.
  output logic            pfail_n,      // Power-fail warning.
  output logic            int_n,        // Interrupt line.
  output logic            supplies_off, // Disable all rails.
  output logic            exit_lp,      // Leave low power.
  output logic            chg_reset,    // Charger reset pulse.
  output logic [3:0]      gpio_dir      // GPIO input select.
);
  pic_pkg::pic_por_t por_q, por_d;
  pic_pkg::pic_i2c_t st_q;
  logic [31:0] cnt_q, cnt_d, por_lim, sd_q, sd_lim;
  logic [7:0]  cs_q, rs_q, m1_q, m2_q, a1_q, a2_q, g3_q;
  logic [7:0]  cs_d, rs_d, a1_d, a2_d, chg_prev_q, reg_prev_q;
  logic [7:0]  reg_src, sh_q, ptr_q, rd_data;
  logic [3:0]  gdet_q, gdet_d, gprev_q, gedge, bc_q;
  logic [2:0]  cause;
  logic        hr_prev_q, pb_prev_q, hr_fall, pb_rise, sys_ok_d;
  logic        scl_q, sda_q, start, stop, scl_rise, scl_fall;
  logic        rw_q, first_q, match, wr_en, rd_load, irq;

  // ------------------------------------------------------------
  // Debounced inputs
  // ------------------------------------------------------------
  pic_dbc_if dl ();
  pic_dbc_if dh ();
  pic_dbc_if dp ();
  assign dl.raw = lid_in;
  assign dh.raw = user_reset_button_n;
  assign dp.raw = pwr_button;

  // R5: three debouncers
  pic_debounce #(.CYC(DBC_CYC), .INIT(1'b0)) u_lid (
    .clk (clk),
    .srst(srst),
    .d   (dl)
  );
  pic_debounce #(.CYC(DBC_CYC), .INIT(1'b1)) u_hot (
    .clk (clk),
    .srst(srst),
    .d   (dh)
  );
  pic_debounce #(.CYC(DBC_CYC), .INIT(1'b0)) u_pwr (
    .clk (clk),
    .srst(srst),
    .d   (dp)
  );

  // Button events act on the debounced levels only.
  assign hr_fall = hr_prev_q && !dh.clean;
  assign pb_rise = !pb_prev_q && dp.clean;

  // ------------------------------------------------------------
  // Reset supervisor
  // ------------------------------------------------------------
  assign por_lim = tpor ? 32'(POR_SLOW) : 32'(POR_FAST);

  // Next state of the supervisor; main rail loss overrides all.
  always_comb
  begin
    por_d = por_q;
    cnt_d = cnt_q + 32'h1;
    case (por_q)
      pic_pkg::POR_HOLD:
      begin
        cnt_d = 32'h0;
        if (main_pgood)
          por_d = pic_pkg::POR_DLY;
      end
      // R1: programmed release delay
      pic_pkg::POR_DLY:
      begin
        if (cnt_q >= por_lim - 32'h1)
        begin
          por_d = pic_pkg::POR_RUN;
          cnt_d = 32'h0;
        end
      end
      // R7: button starts processor reset
      pic_pkg::POR_RUN:
      begin
        cnt_d = 32'h0;
        if (hr_fall)
          por_d = lp_mode ? pic_pkg::POR_CWAIT : pic_pkg::POR_CPULSE;
      end
      pic_pkg::POR_CWAIT:
      begin
        cnt_d = 32'h0;
        if (core_pgood)
          por_d = pic_pkg::POR_CPULSE;
      end
      pic_pkg::POR_CPULSE:
      begin
        if (cnt_q >= 32'(CPU_CYC) - 32'h1)
        begin
          por_d = pic_pkg::POR_RUN;
          cnt_d = 32'h0;
        end
      end
      default:
      begin
        por_d = pic_pkg::POR_HOLD;
        cnt_d = 32'h0;
      end
    endcase
    // R2: rail out of window
    if (!main_pgood)
    begin
      por_d = pic_pkg::POR_HOLD;
      cnt_d = 32'h0;
    end
  end

  assign sys_ok_d = (por_d == pic_pkg::POR_RUN) ||
                    (por_d == pic_pkg::POR_CWAIT) ||
                    (por_d == pic_pkg::POR_CPULSE);
  // R3: power-fail causes
  assign cause    = {!dl.clean, overtemp, uvlo};
  assign sd_lim   = cause[0] ? 32'(SD_UVLO) :
                    cause[1] ? 32'(SD_HOT) : 32'(SD_LID);

  // Supervisor registers and the reset-side outputs.
  // R1: outputs held with reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      por_q     <= pic_pkg::POR_HOLD;
      cnt_q     <= 32'h0;
      sys_rst_n <= 1'b0;
      cpu_rst_n <= 1'b0;
      pfail_n   <= 1'b0;
    end
    else
    begin
      por_q     <= por_d;
      cnt_q     <= cnt_d;
      sys_rst_n <= sys_ok_d;
      cpu_rst_n <= (por_d == pic_pkg::POR_RUN) ||
                   (por_d == pic_pkg::POR_CWAIT);
      pfail_n   <= sys_ok_d && (cause == 3'h0);
    end
  end

  // R4: delayed supply cut
  always_ff @(posedge clk)
  begin
    if (srst || cause == 3'h0)
    begin
      sd_q         <= 32'h0;
      supplies_off <= 1'b0;
    end
    else
    begin
      sd_q         <= (sd_q < sd_lim) ? sd_q + 32'h1 : sd_q;
      supplies_off <= sd_q >= sd_lim - 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Status, acknowledge and GPIO detect
  // ------------------------------------------------------------
  // Edge bits stay until the source is low and already acked;
  // level bits simply follow the source. Set beats clear.
  function automatic logic [7:0] stat_next(
    input logic [7:0] stat, src, prev, ack, edg, lvl);
    stat_next = (edg & (stat | (src & ~prev)) & ~(~src & ack)) |
                (lvl & src);
  endfunction

  // R6: lid removal flagged
  // R9: button, lid, undervoltage
  assign reg_src = {dp.clean, !dl.clean, uvlo, 1'b0, reg_fail};
  // R16: charge edge bits
  // R17: charge level bits
  assign cs_d = stat_next(cs_q, chg_src, chg_prev_q, a1_q,
                          `PIC_CHG_EDGE, `PIC_CHG_LEVEL);
  // R18: regulator edge bits
  // R19: power-good level bits
  assign rs_d = stat_next(rs_q, reg_src, reg_prev_q, a2_q,
                          `PIC_REG_EDGE, `PIC_REG_LEVEL);

  // R14: read sets acknowledge
  // R20: ack follows status
  assign a1_d = (wr_en && ptr_q == `PIC_OFS_CHG_ACK) ? sh_q & cs_d :
                (a1_q | ((rd_load && ptr_q == `PIC_OFS_CHG_STAT) ?
                 cs_q : 8'h00)) & cs_d;
  assign a2_d = (wr_en && ptr_q == `PIC_OFS_REG_ACK) ? sh_q & rs_d :
                (a2_q | ((rd_load && ptr_q == `PIC_OFS_REG_STAT) ?
                 rs_q : 8'h00)) & rs_d;

  // R11: edge polarity select
  assign gedge  = gpio_dir & ((g3_q[7:4] & gpio_in & ~gprev_q) |
                  (~g3_q[7:4] & ~gpio_in & gprev_q));
  // A written one clears a detect flag; a new edge still wins.
  assign gdet_d = gedge | (gdet_q & ~((wr_en &&
                  ptr_q == `PIC_OFS_GPIO_DEF) ? sh_q[3:0] : 4'h0));

  // R24: pending unmasked source
  // R10: any source, one line
  // R21: GPIO blocked by mask
  assign irq = |(cs_q & ~m1_q & ~a1_q) | |(rs_q & ~m2_q & ~a2_q) |
               |(gdet_q & ~g3_q[3:0]);

  // R13: capture regardless of mask
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cs_q <= `PIC_RST_ZERO;
      rs_q <= `PIC_RST_ZERO;
      a1_q <= `PIC_RST_ZERO;
      a2_q <= `PIC_RST_ZERO;
      chg_prev_q <= `PIC_RST_ZERO;
      reg_prev_q <= `PIC_RST_ZERO;
      gdet_q <= 4'h0;
      gprev_q <= 4'h0;
    end
    else
    begin
      cs_q <= cs_d;
      rs_q <= rs_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
      chg_prev_q <= chg_src;
      reg_prev_q <= reg_src;
      gdet_q <= gdet_d;
      gprev_q <= gpio_in;
    end
  end

  // Control registers and pulse outputs.
  // R12: masked after reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      m1_q <= `PIC_RST_MASK;
      m2_q <= `PIC_RST_MASK;
      g3_q <= `PIC_RST_GPIO_MASK;
      gpio_dir <= 4'h0;
      hr_prev_q <= 1'b1;
      pb_prev_q <= 1'b0;
      int_n <= 1'b0;
      exit_lp <= 1'b0;
      chg_reset <= 1'b0;
    end
    else
    begin
      if (wr_en && ptr_q == `PIC_OFS_CHG_MASK)
        m1_q <= sh_q;
      if (wr_en && ptr_q == `PIC_OFS_REG_MASK)
        m2_q <= sh_q;
      if (wr_en && ptr_q == `PIC_OFS_GPIO_MASK)
        g3_q <= sh_q;
      if (wr_en && ptr_q == `PIC_OFS_GPIO_DEF)
        gpio_dir <= sh_q[7:4];
      hr_prev_q <= dh.clean;
      pb_prev_q <= dp.clean;
      int_n <= sys_ok_d && !irq;
      // R8: button wakes device
      exit_lp <= lp_mode && (hr_fall || pb_rise);
      // R23: written bits reset charger
      chg_reset <= wr_en && ptr_q == `PIC_OFS_CHG_STAT &&
                   |(sh_q & `PIC_CHG_WCLR);
    end
  end

  // ------------------------------------------------------------
  // I2C slave port
  // ------------------------------------------------------------
  assign start    = scl_i && scl_q && sda_q && !sda_i;
  assign stop     = scl_i && scl_q && !sda_q && sda_i;
  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign match    = sh_q[7:1] == {`PIC_I2C_ADDR6, addr_lsb};
  assign wr_en    = st_q == pic_pkg::I2C_WR && scl_fall &&
                    bc_q == 4'h8 && !first_q && !start && !stop;
  // R15: snapshot before shifting
  assign rd_load  = scl_fall && !start && !stop &&
                    ((st_q == pic_pkg::I2C_AACK && rw_q) ||
                     st_q == pic_pkg::I2C_RACK);

  // Read data select; unmapped offsets read all ones.
  // R22: direction and detect states
  always_comb
  begin
    if (ptr_q == `PIC_OFS_CHG_STAT)       rd_data = cs_q;
    else if (ptr_q == `PIC_OFS_REG_STAT)  rd_data = rs_q;
    else if (ptr_q == `PIC_OFS_CHG_MASK)  rd_data = m1_q;
    else if (ptr_q == `PIC_OFS_REG_MASK)  rd_data = m2_q;
    else if (ptr_q == `PIC_OFS_CHG_ACK)   rd_data = a1_q;
    else if (ptr_q == `PIC_OFS_REG_ACK)   rd_data = a2_q;
    else if (ptr_q == `PIC_OFS_GPIO_MASK) rd_data = g3_q;
    else if (ptr_q == `PIC_OFS_GPIO_DEF)  rd_data = {gpio_dir, gdet_q};
    else                                  rd_data = `PIC_RD_UNMAPPED;
  end

  // Byte engine. The data line only changes while the clock is low.
  always_ff @(posedge clk)
  begin
    scl_q <= srst ? 1'b1 : scl_i;
    sda_q <= srst ? 1'b1 : sda_i;
    sda_o <= 1'b0;
    if (srst || stop)
    begin
      st_q <= pic_pkg::I2C_IDLE;
      sda_oe <= 1'b0;
      if (srst)
      begin
        sh_q <= 8'h00;
        ptr_q <= 8'h00;
        bc_q <= 4'h0;
        rw_q <= 1'b0;
        first_q <= 1'b0;
      end
    end
    else if (start)
    begin
      st_q <= pic_pkg::I2C_ADDR;
      bc_q <= 4'h0;
      sda_oe <= 1'b0;
    end
    else
      case (st_q)
        pic_pkg::I2C_ADDR, pic_pkg::I2C_WR:
          if (scl_rise)
          begin
            sh_q <= {sh_q[6:0], sda_i};
            bc_q <= bc_q + 4'h1;
          end
          else if (scl_fall && bc_q == 4'h8)
          begin
            if (st_q == pic_pkg::I2C_ADDR && !match)
              st_q <= pic_pkg::I2C_IDLE;
            else
            begin
              st_q <= pic_pkg::I2C_AACK;
              sda_oe <= 1'b1;
              first_q <= st_q == pic_pkg::I2C_ADDR;
              if (st_q == pic_pkg::I2C_ADDR)
                rw_q <= sh_q[0];
              else if (first_q)
                ptr_q <= sh_q;
            end
          end
        pic_pkg::I2C_AACK:
          if (scl_fall)
          begin
            bc_q <= 4'h0;
            st_q <= rw_q ? pic_pkg::I2C_RD : pic_pkg::I2C_WR;
            sh_q <= rw_q ? rd_data : sh_q;
            sda_oe <= rw_q && !rd_data[7];
          end
        pic_pkg::I2C_RD:
          if (scl_fall && bc_q == 4'h7)
          begin
            st_q <= pic_pkg::I2C_RACK;
            sda_oe <= 1'b0;
          end
          else if (scl_fall)
          begin
            sh_q <= {sh_q[6:0], 1'b0};
            sda_oe <= !sh_q[6];
            bc_q <= bc_q + 4'h1;
          end
        pic_pkg::I2C_RACK:
          if (scl_rise && sda_i)
            st_q <= pic_pkg::I2C_IDLE;
          else if (scl_fall)
          begin
            st_q <= pic_pkg::I2C_RD;
            bc_q <= 4'h0;
            sh_q <= rd_data;
            sda_oe <= !rd_data[7];
          end
        default:
          st_q <= pic_pkg::I2C_IDLE;
      endcase
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  rail_loss_a: assert property (!main_pgood |=> !sys_rst_n) // R2
    else $error("system reset not asserted on rail loss");
  reset_group_a: assert property // R1
    (!sys_rst_n |-> !cpu_rst_n && !pfail_n && !int_n)
    else $error("output released during system reset");
  pfail_cause_a: assert property ((uvlo || overtemp) |=> !pfail_n) // R3
    else $error("power fail not signalled");
  supply_cut_a: assert property // R4
    ($rose(supplies_off) |-> !pfail_n && !$past(pfail_n))
    else $error("supplies cut without warning");
  ack_subset_a: assert property ((a1_q & ~cs_q) == 8'h00) // R20
    else $error("acknowledge without status");
  edge_clear_a: assert property ($fell(cs_q[5]) |-> $past(a1_q[5])) // R16
    else $error("edge status cleared without ack");
  level_follow_a: assert property (chg_src[7] |=> cs_q[7]) // R17
    else $error("level status not following source");
  masked_quiet_a: assert property // R12
    ((m1_q == 8'hff && m2_q == 8'hff && &g3_q[3:0] && sys_ok_d) |=> int_n)
    else $error("interrupt with all sources masked");
  read_ack_a: assert property // R14
    ((rd_load && ptr_q == `PIC_OFS_REG_STAT) |=> (a2_q & $past(rs_q) &
     rs_q) == ($past(rs_q) & rs_q))
    else $error("status read did not acknowledge");

  read_ack_c: cover property (rd_load && ptr_q == `PIC_OFS_CHG_STAT);
  cpu_pulse_c: cover property ($rose(cpu_rst_n) && sys_rst_n);
  cut_c: cover property ($rose(supplies_off));
  gpio_c: cover property (|gedge && !int_n);
endmodule // pic_top

// ---- test/pic_i2c_host.sv ----
// Purpose: Processor-side serial host that reads and writes registers.
// Assumes: Data line has a pull-up; the bench resolves all drivers.
// Notes:   Four clocks per phase, far slower than the device samples.
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_i2c_host (
  input  wire logic clk,   // System clock.
  input  wire logic sda,   // Resolved data line.
  output logic      scl,   // Serial clock.
  output logic      sda_m  // Data, 1 releases the line.
);
  // -------------------------------------------------------------------
  // Bit and byte level
  // -------------------------------------------------------------------
  localparam logic [7:0] WADDR = {`PIC_I2C_ADDR6, 2'b00};
  int nacks = 0; // Bytes the device did not acknowledge.
  initial scl = 1'b1;
  initial sda_m = 1'b1;

  task automatic ph();
    repeat (4) @(posedge clk);
  endtask

  // Data only moves while the clock is low, so no false start or stop.
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    ph();
    scl <= 1'b1;
    ph();
    r = sda;
    scl <= 1'b0;
    ph();
  endtask

  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0)
      nacks++;
  endtask

  // Only single-byte reads are made, so the byte is always refused.
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask

  task automatic start();
    sda_m <= 1'b1;
    ph();
    scl <= 1'b1;
    ph();
    sda_m <= 1'b0;
    ph();
    scl <= 1'b0;
    ph();
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    sda_m <= 1'b1;
    ph();
  endtask

  // -------------------------------------------------------------------
  // Register access
  // -------------------------------------------------------------------
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    tx(WADDR);
    tx(p);
    tx(d);
    stop();
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    start();
    tx(WADDR);
    tx(p);
    start();
    tx(WADDR | 8'h01);
    rx(d);
    stop();
  endtask
endmodule // pic_i2c_host

// ---- test/test_pmic_interrupt_and_reset_control.sv ----
// Purpose: Register-level test of the interrupt and reset controller.
// Assumes: Short counts by parameter; serial address bit 0 tied low.
// Notes:   Outputs are read at an edge, before that edge's updates.
`timescale 1ns/1ns
module test_pmic_interrupt_and_reset_control;
  logic       clk = 1'b0, srst = 1'b1;                // Clock, reset.
  logic       addr_lsb = 1'b0, tpor = 1'b0;           // Tied straps.
  logic       core_pgood = 1'b1, lp_mode = 1'b0;      // Core, sleep.
  logic [3:0] reg_fail = 4'h0;                        // Tied rails.
  logic       main_pgood = 1'b1, uvlo = 1'b0;         // Supply sense.
  logic       overtemp = 1'b0, lid_in = 1'b1;         // Faults, lid.
  logic       user_reset_button_n = 1'b1, pwr_button = 1'b0;  // Buttons.
  logic [7:0] chg_src = 8'h00;                        // Charger.
  logic [3:0] gpio_in = 4'h0, gpio_dir;               // GPIO.
  logic       scl, sda_m, sda, sda_o, sda_oe;         // Serial lines.
  logic       sys_rst_n, cpu_rst_n, pfail_n, int_n;   // Resets, irq.
  logic       supplies_off, exit_lp, chg_reset;       // Controls.
  int         mismatches = 0, comparisons = 0, pulses = 0, wakes = 0, n;
  logic [7:0] d;
  logic [7:0] ofs [6] = '{8'h03, 8'h04, 8'h0f, 8'h05, 8'h10, 8'h20};
  logic [7:0] rv [6] = '{8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'hff};

  // Open-drain data line with pull-up.
  assign sda = sda_m & ~(sda_oe & ~sda_o);

  pic_top #(.DBC_CYC(4), .POR_FAST(10), .POR_SLOW(20), .CPU_CYC(5),
    .SD_UVLO(3), .SD_HOT(4), .SD_LID(6)) pic_top_inst (
    .clk, .srst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .addr_lsb,
    .tpor, .main_pgood, .core_pgood, .uvlo, .overtemp, .lid_in,
    .user_reset_button_n, .pwr_button, .lp_mode, .chg_src, .reg_fail, .gpio_in,
    .sys_rst_n, .cpu_rst_n, .pfail_n, .int_n, .supplies_off, .exit_lp,
    .chg_reset, .gpio_dir);

  pic_i2c_host pic_i2c_host_inst (.clk, .sda, .scl, .sda_m);

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (chg_reset === 1'b1) pulses++;
  always @(posedge clk) if (exit_lp === 1'b1) wakes++;

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    pic_i2c_host_inst.rd(p, d);
    chk(d, exp);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A full run takes some 9000 cycles.
  initial
  begin
    wt(60000);
    mismatches++;
    report_and_stop();
  end

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  initial
  begin
    wt(6);
    srst <= 1'b0;
    wt(5);
    chk(8'({sys_rst_n, cpu_rst_n, pfail_n, int_n}), 8'h0);
    wt(20);
    chk(8'({sys_rst_n, pfail_n, int_n}), 8'h7);
    pic_i2c_host_inst.rd(8'h02, d);
    for (int i = 0; i < 6; i++)
      rdc(ofs[i], rv[i]);
    chg_src <= 8'ha1;
    wt(3);
    chg_src <= 8'h80;
    wt(3);
    chk(8'(int_n), 8'h1);
    pic_i2c_host_inst.wr(8'h03, 8'hfe);
    chk(8'(int_n), 8'h0);
    rdc(8'h01, 8'ha1);
    chk(8'(int_n), 8'h1);
    chg_src <= 8'h00;
    wt(3);
    rdc(8'h01, 8'h00);
    rdc(8'h05, 8'h00);
    pic_i2c_host_inst.wr(8'h01, 8'he1);
    pic_i2c_host_inst.wr(8'h01, 8'h02);
    chk(8'(pulses), 8'h1);
    pic_i2c_host_inst.wr(8'h0f, 8'h1e);
    pic_i2c_host_inst.wr(8'h10, 8'h10);
    gpio_in <= 4'h1;
    wt(3);
    chk(8'({gpio_dir, 3'h0, int_n}), 8'h10);
    rdc(8'h10, 8'h11);
    pic_i2c_host_inst.wr(8'h0f, 8'h1f);
    chk(8'(int_n), 8'h1);
    pwr_button <= 1'b1;
    wt(2);
    pwr_button <= 1'b0;
    wt(8);
    rdc(8'h02, 8'h00);
    pwr_button <= 1'b1;
    wt(8);
    pwr_button <= 1'b0;
    wt(8);
    rdc(8'h02, 8'h80);
    rdc(8'h02, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      {overtemp, uvlo} <= 2'(k + 1);
      wt(2);
      chk(8'({pfail_n, supplies_off}), 8'h0);
      wt(k + 4);
      chk(8'(supplies_off), 8'h1);
      {overtemp, uvlo} <= 2'b00;
      wt(10);
    end
    user_reset_button_n <= 1'b0;
    n = 0;
    while (cpu_rst_n !== 1'b0 && n < 30)
    begin
      wt(1);
      n++;
    end
    user_reset_button_n <= 1'b1;
    n = 0;
    while (cpu_rst_n === 1'b0 && n < 30)
    begin
      wt(1);
      n++;
    end
    chk(8'(n), 8'h05);
    {lp_mode, core_pgood, pwr_button} <= 3'b101;
    wt(8);
    user_reset_button_n <= 1'b0;
    wt(10);
    chk(8'({cpu_rst_n, 3'h0, 4'(wakes)}), 8'h82);
    core_pgood <= 1'b1;
    wt(2);
    chk(8'(cpu_rst_n), 8'h00);
    main_pgood <= 1'b0;
    wt(2);
    chk(8'({sys_rst_n, cpu_rst_n, pfail_n, int_n}), 8'h0);
    chk(8'(pic_i2c_host_inst.nacks), 8'h00);
    report_and_stop();
  end
endmodule // test_pmic_interrupt_and_reset_control
